// File: hdl/otss_pkg.sv
`default_nettype none
package otss_pkg;

  // ************************************************************
  // Parameter word addresses
  // ************************************************************
  localparam logic [15:0] ADDR_INPUT_ONE_FAULT_ROUTE  = 16'h0408;
  localparam logic [15:0] ADDR_INPUT_TWO_FAULT_ROUTE  = 16'h0409;
  localparam logic [15:0] ADDR_DIGITAL_OUTPUT_STATE   = 16'h0410;
  localparam logic [15:0] ADDR_ANALOG_OUTPUT_PERCENT  = 16'h0413;
  localparam logic [15:0] ADDR_HOURS_LIMIT_ROUTE      = 16'h041f;
  localparam logic [15:0] ADDR_CYCLES_LIMIT_ROUTE     = 16'h0420;

  // ************************************************************
  // Reset values and encodings
  // ************************************************************
  localparam logic [15:0] ROUTE_RESET     = 16'h0000;
  localparam logic [15:0] ROUTE_ACTIVE    = 16'h0001;
  localparam logic [15:0] ROUTE_INACTIVE  = 16'h0000;
  localparam logic [15:0] RDATA_UNMAPPED  = 16'h0000;
  localparam int          SRC_COUNT       = 4;
  localparam int          SYNC_STAGES     = 3;

endpackage
`default_nettype wire

// File: hdl/otss_sync.sv
`default_nettype none
module otss_sync
  import otss_pkg::*;
#(
  parameter int WIDTH = SRC_COUNT
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Asynchronous levels in, filtered levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } otss_sync_s;

  otss_sync_s st_q;
  otss_sync_s st_d;

  // ************************************************************
  // Three stages; a change counts once stages two and three agree
  // ************************************************************
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.level[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.level;

endmodule
`default_nettype wire

// File: hdl/otss_regs.sv
// Operation
// - Input one fault enable drives output
// - Input two fault enable drives output
// - Hours limit enable activates output
// - Cycles limit enable activates output
// - Read-only digital output state, 0/1
// - Read-only analog output percent value
`default_nettype none
module otss_regs
  import otss_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Parameter word access from the fieldbus engine
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   reg_rvalid,
  output logic                   reg_err,
  // Event sources from other parts of the controller
  input  wire logic              analog_input_one_fault,
  input  wire logic              analog_input_two_fault,
  input  wire logic              hours_limit_reached,
  input  wire logic              cycles_limit_reached,
  // Analog output level, percent of full scale
  input  wire logic [DATA_W-1:0] analog_output_level,
  // Digital output drive
  output logic                   digital_output_on
);

  // ************************************************************
  // State, registered as one record
  // ************************************************************
  typedef struct packed {
    // Route words are stored as written and decoded on use
    logic [SRC_COUNT-1:0][DATA_W-1:0] route;
    logic                             out_on;
    logic [DATA_W-1:0]                analog_pct;
    logic [DATA_W-1:0]                rdata;
    logic                             rvalid;
    logic                             err;
  } otss_regs_s;

  otss_regs_s st_q;
  otss_regs_s st_d;

  // ************************************************************
  // Route word per source, in event vector order
  // ************************************************************
  localparam logic [15:0] ROUTE_ADDR [SRC_COUNT] = '{
    ADDR_INPUT_ONE_FAULT_ROUTE,
    ADDR_INPUT_TWO_FAULT_ROUTE,
    ADDR_HOURS_LIMIT_ROUTE,
    ADDR_CYCLES_LIMIT_ROUTE
  };

  // ************************************************************
  // Internal signals
  // ************************************************************
  // Event path
  logic [SRC_COUNT-1:0] ev_raw;
  logic [SRC_COUNT-1:0] ev_sync;
  logic [SRC_COUNT-1:0] ev_enable;
  logic [SRC_COUNT-1:0] ev_fire;
  // Bus decode
  logic [SRC_COUNT-1:0] route_hit;
  logic [SRC_COUNT-1:0] route_wr;
  logic                 wr_take;
  logic                 rd_take;
  logic                 state_hit;
  logic                 level_hit;
  logic                 mapped;
  logic                 wr_refused;
  logic [DATA_W-1:0]    rd_mux;

  // ************************************************************
  // Route word decode
  // ************************************************************
  // Only the value 1 enables; any other stored value acts as 0
  function automatic logic route_active(input logic [DATA_W-1:0] word);
    return (word == DATA_W'(ROUTE_ACTIVE));
  endfunction

  // ************************************************************
  // Event inputs
  // ************************************************************
  // Sources may come from slower logic; the filter costs a few
  // cycles of delay but keeps a short glitch off the output
  assign ev_raw = {cycles_limit_reached, hours_limit_reached,
                   analog_input_two_fault, analog_input_one_fault};

  otss_sync #(
    .WIDTH (SRC_COUNT)
  ) u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (ev_raw),
    .sync_out (ev_sync)
  );

  // ************************************************************
  // Bus decode
  // ************************************************************
  // A write wins over a read presented on the same edge
  assign wr_take = reg_wr;
  assign rd_take = reg_rd && !reg_wr;

  always_comb begin
    state_hit = 1'b0;
    level_hit = 1'b0;
    mapped    = 1'b0;
    case (reg_addr)
      ADDR_DIGITAL_OUTPUT_STATE: begin
        state_hit = 1'b1;
        mapped    = 1'b1;
      end
      ADDR_ANALOG_OUTPUT_PERCENT: begin
        level_hit = 1'b1;
        mapped    = 1'b1;
      end
      ADDR_INPUT_ONE_FAULT_ROUTE,
      ADDR_INPUT_TWO_FAULT_ROUTE,
      ADDR_HOURS_LIMIT_ROUTE,
      ADDR_CYCLES_LIMIT_ROUTE: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Read-only and unmapped words refuse writes and keep their value
  assign wr_refused = wr_take && !(|route_hit);

  // ************************************************************
  // Per-source decode and enable
  // ************************************************************
  for (genvar g = 0; g < SRC_COUNT; g++) begin : g_src
    assign route_hit[g] = (reg_addr == ROUTE_ADDR[g]);
    assign route_wr[g]  = wr_take && route_hit[g];
    assign ev_enable[g] = route_active(st_q.route[g]);
    assign ev_fire[g]   = ev_sync[g] && ev_enable[g];
  end

  // ************************************************************
  // Read data select
  // ************************************************************
  always_comb begin
    rd_mux = DATA_W'(RDATA_UNMAPPED);
    for (int i = 0; i < SRC_COUNT; i++) begin
      if (route_hit[i]) begin
        rd_mux = st_q.route[i];
      end
    end
    if (state_hit) begin
      rd_mux = {{(DATA_W-1){1'b0}}, st_q.out_on};
    end
    if (level_hit) begin
      rd_mux = st_q.analog_pct;
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_d            = st_q;
    st_d.rvalid     = 1'b0;
    st_d.err        = 1'b0;
    // Any one enabled and active source switches the output on
    st_d.out_on     = |ev_fire;
    // Registered so that a read sees the level of one cycle before
    st_d.analog_pct = analog_output_level;
    for (int i = 0; i < SRC_COUNT; i++) begin
      if (route_wr[i]) begin
        st_d.route[i] = reg_wdata;
      end
    end
    case ({wr_take, rd_take})
      2'b10: begin
        st_d.err = wr_refused;
      end
      2'b01: begin
        st_d.rvalid = 1'b1;
        st_d.err    = !mapped;
        st_d.rdata  = rd_mux;
      end
      default: begin
        // No access; answer pulses fall after one cycle
        st_d.rvalid = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Routes leave reset not active, so nothing drives the output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q       <= '0;
      st_q.route <= {SRC_COUNT{DATA_W'(ROUTE_RESET)}};
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Read data holds until the next read
  assign reg_rdata         = st_q.rdata;
  assign reg_rvalid        = st_q.rvalid;
  assign reg_err           = st_q.err;
  assign digital_output_on = st_q.out_on;

endmodule
`default_nettype wire

// File: sim/otss_regs_checker.sv
`default_nettype none
module otss_regs_checker
  import otss_pkg::*;
#(parameter int DATA_W = 16) (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_err,
  // Events and outputs
  input wire logic analog_input_one_fault,
  input wire logic analog_input_two_fault,
  input wire logic hours_limit_reached,
  input wire logic cycles_limit_reached,
  input wire logic [DATA_W-1:0] analog_output_level,
  input wire logic digital_output_on
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] src;
  logic [3:0] en_q;
  logic rd_ok;
  assign src = {cycles_limit_reached, hours_limit_reached,
                analog_input_two_fault, analog_input_one_fault};
  assign rd_ok = reg_rd && !reg_wr;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ***
  // Shadow routes, only the value 1 enables
  // ***
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_INPUT_ONE_FAULT_ROUTE) en_q[0] <= reg_wdata == 1;
      if (reg_addr == ADDR_INPUT_TWO_FAULT_ROUTE) en_q[1] <= reg_wdata == 1;
      if (reg_addr == ADDR_HOURS_LIMIT_ROUTE) en_q[2] <= reg_wdata == 1;
      if (reg_addr == ADDR_CYCLES_LIMIT_ROUTE) en_q[3] <= reg_wdata == 1;
    end
  end
  property p_on(int i);
    (en_q[i] && src[i]) [*8] |=> digital_output_on;
  endproperty
  a_fault_one_on: assert property (p_on(0)) else $error("no output");
  a_fault_two_on: assert property (p_on(1)) else $error("no output");
  a_hours_on: assert property (p_on(2)) else $error("no output");
  a_cycles_on: assert property (p_on(3)) else $error("no output");
  a_idle_output_off: assert property (((src & en_q) == 4'h0) [*8]
    |=> !digital_output_on) else $error("output on without source");
  a_state_read: assert property (rd_ok &&
    reg_addr == ADDR_DIGITAL_OUTPUT_STATE |=> reg_rvalid &&
    reg_rdata == DATA_W'($past(digital_output_on))) else $error("bad state");
  a_level_read: assert property (rd_ok &&
    reg_addr == ADDR_ANALOG_OUTPUT_PERCENT |=>
    reg_rdata == $past(analog_output_level, 2)) else $error("bad level");
  a_ro_write_err: assert property (reg_wr &&
    reg_addr == ADDR_DIGITAL_OUTPUT_STATE |=> reg_err) else $error("no err");
  c_output_on: cover property (digital_output_on);
  c_level_read: cover property (rd_ok &&
    reg_addr == ADDR_ANALOG_OUTPUT_PERCENT);
  c_refused: cover property (reg_err);
endmodule
`default_nettype wire

// File: sim/otss_bus_master.sv
`default_nettype none
module otss_bus_master (
  // Bus
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_err
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 34'h0;
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk);
    {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask
  // Answer flags come back as {valid, error}
  task automatic rd(input logic [15:0] a, output logic [17:0] f);
    @(negedge clk);
    {reg_rd, reg_addr} = {1'b1, a};
    // The answer stands for one cycle after the read edge
    @(negedge clk);
    f = {reg_rvalid, reg_err, reg_rdata};
    reg_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: sim/otss_regs_tb.sv
`default_nettype none
module otss_regs_tb
  import otss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, arst_n = 0, wr, rd, rv, er, on;
  logic [15:0] addr, wd, rdat, lvl = 16'h0042;
  logic [3:0] src = 4'h0;
  logic [17:0] f;
  int bad_count = 0, checks = 0;
  localparam logic [15:0] RA [4] = '{ADDR_INPUT_ONE_FAULT_ROUTE,
    ADDR_INPUT_TWO_FAULT_ROUTE, ADDR_HOURS_LIMIT_ROUTE,
    ADDR_CYCLES_LIMIT_ROUTE};
  always #2 clk = ~clk;
  otss_regs DUT (.clk(clk), .arst_n(arst_n), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv),
    .reg_err(er), .analog_input_one_fault(src[0]),
    .analog_input_two_fault(src[1]), .hours_limit_reached(src[2]),
    .cycles_limit_reached(src[3]), .analog_output_level(lvl),
    .digital_output_on(on));
  otss_bus_master MST (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv), .reg_err(er));
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic settle;
    repeat (10) @(negedge clk);
  endtask
  initial begin
    #8000 bad_count++;
    end_of_test();
  end
  initial begin
    settle();
    arst_n = 1;
    foreach (RA[i]) begin
      MST.rd(RA[i], f);
      chk(f, {2'b10, ROUTE_RESET});
      MST.wr(RA[i], ROUTE_ACTIVE);
      @(negedge clk) src[i] = 1'b1;
      settle();
      MST.rd(ADDR_DIGITAL_OUTPUT_STATE, f);
      chk(f, 18'h2_0001);
      MST.wr(RA[i], 16'h0002);
      settle();
      chk({17'h0, on}, 18'h0);
      src[i] = 1'b0;
    end
    $display("test single_sources done");
    MST.wr(RA[0], ROUTE_ACTIVE);
    MST.wr(RA[3], ROUTE_ACTIVE);
    @(negedge clk) src = 4'h6;
    settle();
    chk({17'h0, on}, 18'h0);
    src = 4'he;
    settle();
    chk({17'h0, on}, 18'h1);
    src = 4'h0;
    settle();
    $display("test or_of_sources done");
    MST.rd(ADDR_ANALOG_OUTPUT_PERCENT, f);
    chk(f, {2'b10, 16'h0042});
    @(negedge clk) lvl = 16'h0064;
    MST.rd(ADDR_ANALOG_OUTPUT_PERCENT, f);
    chk(f, {2'b10, 16'h0064});
    MST.wr(ADDR_DIGITAL_OUTPUT_STATE, 16'h0001);
    MST.rd(ADDR_DIGITAL_OUTPUT_STATE, f);
    chk(f, 18'h2_0000);
    MST.rd(16'h0411, f);
    chk(f, {2'b11, RDATA_UNMAPPED});
    $display("test read_only done");
    end_of_test();
  end
endmodule
bind otss_regs otss_regs_checker #(.DATA_W(DATA_W)) CHK (.clk(clk),
  .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .reg_err(reg_err), .analog_input_one_fault(analog_input_one_fault),
  .analog_input_two_fault(analog_input_two_fault),
  .hours_limit_reached(hours_limit_reached),
  .cycles_limit_reached(cycles_limit_reached),
  .analog_output_level(analog_output_level),
  .digital_output_on(digital_output_on));
`default_nettype wire
